// File: src/cctb_pkg.sv
// package with register map, field layout and types for the capture/compare timebase
package cctb_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [15:0] UNIT2_TIMER_CONTROL_OFS = 16'hff20;
  localparam logic [15:0] UNIT1_TIMER_CONTROL_OFS = 16'hff50;
  // timer value, reload value and capture/compare register blocks
  localparam logic [15:0] TIMER_VALUE_BASE        = 16'hfe00; // four words, a-timer then b-timer, unit1 then unit2
  localparam logic [15:0] TIMER_RELOAD_BASE       = 16'hfe10; // four words, same order
  localparam logic [15:0] CC_MODE_BASE            = 16'hfe20; // 32 words, one per register
  localparam logic [15:0] CC_VALUE_BASE           = 16'hfe80; // 32 words, one per register
  localparam logic [15:0] CC_PIN_STATE_OFS        = 16'hff00; // compare pin levels, read only

  // ****************************************************************
  // timer control byte layout
  // ****************************************************************
  localparam int RUN_BIT_POS  = 6;
  localparam int MODE_BIT_POS = 3;
  localparam int SEL_LSB      = 0;
  localparam int SEL_W        = 3;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [15:0] CONTROL_RESET  = 16'h0000;
  localparam int          PRESCALE_BASE  = 3;       // divisor is 2**(select+3)
  localparam int          SYNC_STAGES    = 2;

  // ****************************************************************
  // capture/compare per-register mode
  // ****************************************************************
  typedef enum logic [2:0] {
    CCTB_CC_OFF     = 3'h0,
    CCTB_CAP_RISE   = 3'h1,
    CCTB_CAP_FALL   = 3'h2,
    CCTB_CAP_BOTH   = 3'h3,
    CCTB_CMP_IRQ    = 3'h4,
    CCTB_CMP_TOGGLE = 3'h5,
    CCTB_CMP_IRQ1   = 3'h6,
    CCTB_CMP_SET    = 3'h7
  } cctb_ccmode_t;

  // decoded timer control byte
  typedef struct packed {
    logic       run;
    logic       mode;
    logic [2:0] sel;
  } cctb_tctl_t;

  // bus request carrier
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } cctb_req_t;

endpackage

// File: src/cctb_top.sv
// two capture/compare units with their timebases, behind an ahb-lite slave
`timescale 1ns/1ps
// Summary of operation
// RULE1: timer mode: increment every 2**(select+3) clocks, divisors 8 to 1024.
// RULE2: counter mode: select x00 neighbour overflow, x01 rise, x10 fall, x11 any edge.
// RULE3: second timer in counter mode stops when select picks any pin-edge source.
// RULE4: mode bit zero picks prescaled clock, one picks events or neighbour overflow.
// RULE5: timer counts only while run bit is one, otherwise holds value.
// RULE6: control low byte drives first timer, high byte second; run 6, mode 3, select 2:0.
// RULE7: timers count only upward.
// RULE8: software reads and writes each timer value.
// RULE9: software write to a timer wins over a same-time increment or reload.
// RULE10: at FFFFh timer loads its reload value instead of wrapping to zero.
// RULE11: first increment within one interval after run, then exactly one interval apart.
// RULE12: simultaneous ticks: first timer serviced one clock before second timer.
// RULE13: sixteen capture/compare registers per unit, each with mode and timer choice.
// RULE14: capture copies the assigned timer on a pin transition.
// RULE15: compare match with assigned timer may change the output pin.
// RULE16: four registers of the second unit capture only, twelve compare outputs.
// RULE17: one request pulse per capture/compare event and per timer overflow.
// RULE18: pin-counted increment visible within 8 clocks of the pin transition.
// RULE19: count pin levels held at least 8 clocks between transitions.
// RULE20: count and capture pins synchronised, edges taken from synchronised signal.
// RULE21: reload replaces the increment in the same cycle, never passing zero.
module cctb_top #(
  parameter int NUM_CC = 32
) (
  // clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_rst_n,
  // ahb-lite slave
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic [31:0]         i_hwdata,
  input  wire logic                i_hready,
  output logic      [31:0]         o_hrdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  // event inputs
  input  wire logic [1:0]          i_count_pin,      // unit1 / unit2 first-timer count pins
  input  wire logic                i_neighbour_ovf,  // one-cycle pulse from neighbour timer
  input  wire logic [NUM_CC-1:0]   i_cc_pin,
  // outputs
  output logic [NUM_CC-1:0]        o_cc_pin,
  output logic [NUM_CC-1:0]        o_cc_pin_oe,
  output logic [NUM_CC-1:0]        o_cc_irq,         // one-cycle pulse per event
  output logic [3:0]               o_timer_irq       // one-cycle pulse per overflow
);

  // ****************************************************************
  // bus slave state
  // ****************************************************************
  cctb_pkg::cctb_req_t req_q, req_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                wr_en;
  logic [15:0]         wr_data;

  // capture address phase; answer reads in the data phase with zero wait states
  always_comb begin
    req_d.valid = i_hsel && i_hready && i_htrans[1];
    req_d.write = i_hwrite;
    req_d.addr  = i_haddr[15:0];
  end

  assign wr_en   = req_q.valid && req_q.write;
  assign wr_data = i_hwdata[15:0];

  // ****************************************************************
  // control and timer state
  // ****************************************************************
  logic [15:0]       ctl_q   [2];
  logic [15:0]       ctl_d   [2];
  logic [15:0]       tmr_q   [4];
  logic [15:0]       tmr_d   [4];
  logic [15:0]       rel_q   [4];
  logic [15:0]       rel_d   [4];
  logic [9:0]        pre_q   [4];
  logic [9:0]        pre_d   [4];
  logic [3:0]        tick_b_q, tick_b_d;   // second timer tick delayed by one clock
  logic [3:0]        ovf_q, ovf_d;
  logic [1:0]        cnt_s1_q, cnt_s2_q, cnt_s3_q;
  logic [NUM_CC-1:0] cc_s1_q, cc_s2_q, cc_s3_q;
  logic [3:0]        tick;

  // decode one control byte into its fields
  function automatic cctb_pkg::cctb_tctl_t dec_ctl(input logic [7:0] b);
    cctb_pkg::cctb_tctl_t t;
    t.run  = b[cctb_pkg::RUN_BIT_POS];   // [RULE6]
    t.mode = b[cctb_pkg::MODE_BIT_POS];
    t.sel  = b[cctb_pkg::SEL_LSB +: cctb_pkg::SEL_W];
    return t;
  endfunction

  // word match for a register address
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // the third stage only keeps the previous synchronised level for edge detection
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_s1_q <= 2'h0;
      cnt_s2_q <= 2'h0;
      cnt_s3_q <= 2'h0;
      cc_s1_q  <= '0;
      cc_s2_q  <= '0;
      cc_s3_q  <= '0;
    end else begin
      cnt_s1_q <= i_count_pin;   // [RULE20]
      cnt_s2_q <= cnt_s1_q;
      cnt_s3_q <= cnt_s2_q;
      cc_s1_q  <= i_cc_pin;      // [RULE20]
      cc_s2_q  <= cc_s1_q;
      cc_s3_q  <= cc_s2_q;
    end
  end

  // ****************************************************************
  // timer tick generation and counting
  // ****************************************************************
  always_comb begin
    cctb_pkg::cctb_tctl_t c;
    logic                 rise;
    logic                 fall;
    logic                 evt;
    logic [9:0]           lim;
    logic                 pend_a;
    logic                 wr_t;
    c      = '0;
    rise   = 1'b0;
    fall   = 1'b0;
    evt    = 1'b0;
    lim    = 10'h000;
    pend_a = 1'b0;
    wr_t   = 1'b0;
    tick   = 4'h0;
    tick_b_d = 4'h0;
    ovf_d  = 4'h0;
    for (int i = 0; i < 2; i++) begin
      ctl_d[i] = ctl_q[i];
    end
    if (wr_en && hit(req_q.addr, cctb_pkg::UNIT1_TIMER_CONTROL_OFS)) begin
      ctl_d[0] = wr_data;
    end
    if (wr_en && hit(req_q.addr, cctb_pkg::UNIT2_TIMER_CONTROL_OFS)) begin
      ctl_d[1] = wr_data;
    end
    for (int t = 0; t < 4; t++) begin
      c        = dec_ctl((t % 2 == 0) ? ctl_q[t / 2][7:0] : ctl_q[t / 2][15:8]); // [RULE6]
      rise     = cnt_s2_q[t / 2] && !cnt_s3_q[t / 2];
      fall     = !cnt_s2_q[t / 2] && cnt_s3_q[t / 2];
      pre_d[t] = pre_q[t];
      rel_d[t] = rel_q[t];
      tmr_d[t] = tmr_q[t];
      evt      = 1'b0;
      if (!c.run) begin
        pre_d[t] = 10'h000;                               // [RULE5]
      end else if (!c.mode) begin
        lim = 10'((11'h001 << (c.sel + cctb_pkg::PRESCALE_BASE)) - 11'h001); // [RULE1] [RULE4]
        if (pre_q[t] >= lim) begin
          pre_d[t] = 10'h000;
          evt      = 1'b1;                                // [RULE11]
        end else begin
          pre_d[t] = pre_q[t] + 10'h001;
        end
      end else begin
        unique case (c.sel[1:0])                          // [RULE2] [RULE4]
          2'b00: evt = i_neighbour_ovf;
          2'b01: evt = (t % 2 == 0) && rise;              // [RULE3]
          2'b10: evt = (t % 2 == 0) && fall;              // [RULE3]
          2'b11: evt = (t % 2 == 0) && (rise || fall);    // [RULE3] [RULE18]
        endcase
      end
      // the second timer lags its partner by one clock
      if (t % 2 == 0) begin
        tick[t] = evt;
      end else begin
        tick_b_d[t] = evt;                                // [RULE12]
        tick[t]     = tick_b_q[t] && c.run;
      end
      pend_a = tick[t];
      wr_t   = wr_en && hit(req_q.addr, cctb_pkg::TIMER_VALUE_BASE + 16'(4 * t));
      if (wr_t) begin
        tmr_d[t] = wr_data;                               // [RULE8] [RULE9]
      end else if (pend_a) begin
        if (tmr_q[t] == 16'hffff) begin
          tmr_d[t] = rel_q[t];                            // [RULE10] [RULE21]
          ovf_d[t] = 1'b1;                                // [RULE17]
        end else begin
          tmr_d[t] = tmr_q[t] + 16'h0001;                 // [RULE7]
        end
      end
      if (wr_en && hit(req_q.addr, cctb_pkg::TIMER_RELOAD_BASE + 16'(4 * t))) begin
        rel_d[t] = wr_data;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctl_q[0] <= cctb_pkg::CONTROL_RESET;
      ctl_q[1] <= cctb_pkg::CONTROL_RESET;
      for (int t = 0; t < 4; t++) begin
        tmr_q[t] <= 16'h0000;
        rel_q[t] <= 16'h0000;
        pre_q[t] <= 10'h000;
      end
      tick_b_q <= 4'h0;
      ovf_q    <= 4'h0;
    end else begin
      ctl_q    <= ctl_d;
      tmr_q    <= tmr_d;
      rel_q    <= rel_d;
      pre_q    <= pre_d;
      tick_b_q <= tick_b_d;
      ovf_q    <= ovf_d;
    end
  end

  // ****************************************************************
  // capture/compare registers
  // ****************************************************************
  logic [2:0]        ccm_q [NUM_CC];
  logic [2:0]        ccm_d [NUM_CC];
  logic              acc_q [NUM_CC];
  logic              acc_d [NUM_CC];
  logic [15:0]       ccv_q [NUM_CC];
  logic [15:0]       ccv_d [NUM_CC];
  logic [NUM_CC-1:0] pin_q, pin_d, oe_q, oe_d, irq_q, irq_d;

  // capture-only channels 24..27 never drive a pin
  function automatic logic can_cmp(input int n);
    return !(n >= 24 && n <= 27);
  endfunction

  always_comb begin
    int          tsel;
    logic        re;
    logic        fe;
    logic        wr_v;
    logic [15:0] tv;
    tsel  = 0;
    re    = 1'b0;
    fe    = 1'b0;
    wr_v  = 1'b0;
    tv    = 16'h0000;
    pin_d = pin_q;
    oe_d  = '0;
    irq_d = '0;
    for (int n = 0; n < NUM_CC; n++) begin
      ccm_d[n] = ccm_q[n];
      acc_d[n] = acc_q[n];
      ccv_d[n] = ccv_q[n];
      tsel     = (n / 16) * 2 + (acc_q[n] ? 1 : 0);     // [RULE13]
      tv       = tmr_q[tsel];
      re       = cc_s2_q[n] && !cc_s3_q[n];
      fe       = !cc_s2_q[n] && cc_s3_q[n];
      wr_v     = wr_en && hit(req_q.addr, cctb_pkg::CC_VALUE_BASE + 16'(4 * n));
      if (wr_en && hit(req_q.addr, cctb_pkg::CC_MODE_BASE + 16'(4 * n))) begin
        ccm_d[n] = wr_data[2:0];
        acc_d[n] = wr_data[3];
      end
      oe_d[n] = ccm_q[n][2] && can_cmp(n);                // [RULE16]
      if (wr_v) begin
        ccv_d[n] = wr_data;
      end else if ((ccm_q[n] == 3'h1 && re) || (ccm_q[n] == 3'h2 && fe) ||
                   (ccm_q[n] == 3'h3 && (re || fe))) begin
        ccv_d[n] = tv;                                    // [RULE14]
        irq_d[n] = 1'b1;                                  // [RULE17]
      end
      // compare fires on the clock the assigned timer takes the matching value
      if (ccm_q[n][2] && can_cmp(n) && tick[tsel] && tmr_d[tsel] == ccv_q[n]) begin
        irq_d[n] = 1'b1;                                  // [RULE15] [RULE17]
        if (ccm_q[n] == 3'h5) begin
          pin_d[n] = !pin_q[n];
        end else if (ccm_q[n] == 3'h7) begin
          pin_d[n] = 1'b1;
        end
      end
      if (ccm_q[n] == 3'h7 && ovf_d[tsel]) begin
        pin_d[n] = 1'b0;                                  // overflow resets set-mode pin
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      for (int n = 0; n < NUM_CC; n++) begin
        ccm_q[n] <= 3'h0;
        acc_q[n] <= 1'b0;
        ccv_q[n] <= 16'h0000;
      end
      pin_q <= '0;
      oe_q  <= '0;
      irq_q <= '0;
    end else begin
      ccm_q <= ccm_d;
      acc_q <= acc_d;
      ccv_q <= ccv_d;
      pin_q <= pin_d;
      oe_q  <= oe_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  // unmapped addresses read zero, response stays okay
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit(req_d.addr, cctb_pkg::UNIT1_TIMER_CONTROL_OFS)) rdata_d = {16'h0000, ctl_d[0]};
    if (hit(req_d.addr, cctb_pkg::UNIT2_TIMER_CONTROL_OFS)) rdata_d = {16'h0000, ctl_d[1]};
    if (hit(req_d.addr, cctb_pkg::CC_PIN_STATE_OFS))        rdata_d = 32'(pin_d);
    for (int t = 0; t < 4; t++) begin
      if (hit(req_d.addr, cctb_pkg::TIMER_VALUE_BASE + 16'(4 * t)))  rdata_d = {16'h0000, tmr_d[t]}; // [RULE8]
      if (hit(req_d.addr, cctb_pkg::TIMER_RELOAD_BASE + 16'(4 * t))) rdata_d = {16'h0000, rel_d[t]};
    end
    for (int n = 0; n < NUM_CC; n++) begin
      if (hit(req_d.addr, cctb_pkg::CC_MODE_BASE + 16'(4 * n)))  rdata_d = {28'h0, acc_d[n], ccm_d[n]};
      if (hit(req_d.addr, cctb_pkg::CC_VALUE_BASE + 16'(4 * n))) rdata_d = {16'h0000, ccv_d[n]};
    end
    if (!req_d.valid) rdata_d = rdata_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      req_q   <= '0;
      rdata_q <= 32'h0000_0000;
    end else begin
      req_q   <= req_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flip-flops; hreadyout and hresp tied to constants
  assign o_hrdata    = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;
  assign o_cc_pin    = pin_q;
  assign o_cc_pin_oe = oe_q;
  assign o_cc_irq    = irq_q;
  assign o_timer_irq = ovf_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_halt_when_stopped: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE5]
    !ctl_q[0][6] && !wr_en |=> tmr_q[0] == $past(tmr_q[0]))
    else $error("stopped timer changed");
  a_reload_not_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE10]
    tick[0] && tmr_q[0] == 16'hffff && !wr_en |=> tmr_q[0] == $past(rel_q[0]) && ovf_q[0])
    else $error("overflow did not reload");
  a_up_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE7]
    tick[2] && tmr_q[2] != 16'hffff && !wr_en |=> tmr_q[2] == $past(tmr_q[2]) + 16'h0001)
    else $error("timer did not step up");
  a_b_lags_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE12]
    ctl_q[0] == 16'h4040 && tick[0] && pre_q[1] == pre_q[0] && !wr_en |=> tick[1] && !tick[0])
    else $error("second timer not one clock behind");
  a_pin_gap: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE3]
    ctl_q[0][11] && ctl_q[0][9:8] != 2'b00 |-> !tick_b_d[1])
    else $error("second timer counted a pin edge");
  a_cap_only_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE16]
    o_cc_pin_oe[27:24] == 4'h0)
    else $error("capture-only channel drives pin");
  a_rate_eight: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE1]
    tick[0] && ctl_q[0][6:0] == 7'h40 ##1 ctl_q[0][6:0] == 7'h40 [*7] |-> ##1 tick[0])
    else $error("divide by eight broken");
  a_write_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // [RULE9]
    wr_en && req_q.addr == cctb_pkg::TIMER_VALUE_BASE |=> tmr_q[0] == $past(wr_data))
    else $error("timer write lost");

endmodule // cctb_top

// File: verification/cctb_event_model.sv
// behavioural source of the count pins and the neighbour overflow pulse
`timescale 1ns/1ps
module cctb_event_model (
  // clock
  input  wire logic       i_core_clk,
  // bench commands
  input  wire logic [1:0] i_flip,
  input  wire logic       i_ovf_req,
  // lines into the block
  output logic      [1:0] o_count_pin,
  output logic            o_neighbour_ovf
);
  logic [1:0] pin_q  = 2'h0;
  logic       ovf_q  = 1'b0;
  logic [3:0] hold_q = 4'h0;

  // a level stands 8 clocks before it may change, so no edge is lost
  always @(posedge i_core_clk) begin
    if (|i_flip && hold_q >= 4'h8) begin
      pin_q  <= pin_q ^ i_flip;
      hold_q <= 4'h0;
    end else if (hold_q != 4'hf) begin
      hold_q <= hold_q + 4'h1;
    end
    ovf_q <= i_ovf_req;
  end

  // pulse lasts one clock, as the neighbour timer gives it
  assign o_count_pin     = pin_q;
  assign o_neighbour_ovf = ovf_q;
endmodule // cctb_event_model

// File: verification/tb_top.sv
// self-checking bench for the capture/compare timebase
`timescale 1ns/1ps
module tb_top;
  // ************************************
  // signals
  // ************************************
  logic        clk     = 1'b0;
  logic        rst_n   = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [1:0]  flip    = 2'h0;
  logic        ovf_req = 1'b0;
  logic [1:0]  cnt_pin;
  logic        nb_ovf;
  logic [31:0] cc_in   = 32'h0;
  logic [31:0] cc_out;
  logic [31:0] cc_oe;
  logic [31:0] cc_irq;
  logic [3:0]  t_irq;
  int          fails     = 0;
  int          tests_run = 0;
  int          cyc       = 0;

  always #5 clk = ~clk;

  cctb_top i_cctb_top (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_count_pin(cnt_pin), .i_neighbour_ovf(nb_ovf),
    .i_cc_pin(cc_in), .o_cc_pin(cc_out), .o_cc_pin_oe(cc_oe), .o_cc_irq(cc_irq), .o_timer_irq(t_irq));

  cctb_event_model i_cctb_event_model (
    .i_core_clk(clk), .i_flip(flip), .i_ovf_req(ovf_req), .o_count_pin(cnt_pin), .o_neighbour_ovf(nb_ovf));

  // ************************************
  // helpers
  // ************************************
  task automatic results();
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // the longest run is the 1024 prescaler, far below this ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask

  // one ahb-lite single transfer; read data taken at the data phase edge
  task automatic xfer(input logic [15:0] a, input logic w, input logic [15:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {16'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 16'h0, q);
    chk(nm, q, e);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  function automatic logic [15:0] tv(input int t);
    return cctb_pkg::TIMER_VALUE_BASE + 16'(4 * t);
  endfunction

  function automatic logic [15:0] tr(input int t);
    return cctb_pkg::TIMER_RELOAD_BASE + 16'(4 * t);
  endfunction

  // control byte of timer t; the partner timer's byte is cleared
  task automatic setctl(input int t, input logic [7:0] b);
    wr(t < 2 ? cctb_pkg::UNIT1_TIMER_CONTROL_OFS : cctb_pkg::UNIT2_TIMER_CONTROL_OFS, t[0] ? {b, 8'h0} : {8'h0, b});
  endtask

  // counts seen for one pin edge arriving at new level lvl
  function automatic int counts(input int s, input logic lvl);
    return int'((s == 3) || (s == 1 && lvl) || (s == 2 && !lvl));
  endfunction

  task automatic wait_irq(input int t, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (t_irq[t] !== 1'b1 && c < 2100);
  endtask

  task automatic pulse();
    ovf_req <= 1'b1;
    @(posedge clk);
    ovf_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial begin
    int t, s, n, k, c0, c1, e;
    logic [15:0] v;
    logic lvl, capc;
    void'($urandom(32'h7f83));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("u1 ctl", cctb_pkg::UNIT1_TIMER_CONTROL_OFS, 32'h0);
    rdchk("u2 ctl", cctb_pkg::UNIT2_TIMER_CONTROL_OFS, 32'h0);
    rdchk("hole", 16'hfffc, 32'h0);
    // timers stopped: value written stays put
    for (t = 0; t < 4; t++) begin
      v = 16'($urandom);
      wr(tv(t), v);
      repeat (20) @(posedge clk);
      rdchk("timer", tv(t), {16'h0, v});
    end
    for (t = 0; t < 4; t += 2) begin
      v = 16'($urandom) & 16'h4f4f;
      setctl(t, v[7:0]);
      wr(t < 2 ? cctb_pkg::UNIT1_TIMER_CONTROL_OFS : cctb_pkg::UNIT2_TIMER_CONTROL_OFS, v);
      rdchk("ctl", t < 2 ? cctb_pkg::UNIT1_TIMER_CONTROL_OFS : cctb_pkg::UNIT2_TIMER_CONTROL_OFS, {16'h0, v});
      setctl(t, 8'h00);
    end
    // every prescaler: reload ffff makes each tick an overflow pulse
    for (s = 0; s < 8; s++) begin
      t = s % 4;
      wr(tr(t), 16'hffff);
      wr(tv(t), 16'hffff);
      setctl(t, 8'h40 | 8'(s));
      wait_irq(t, c0);
      wait_irq(t, c1);
      setctl(t, 8'h00);
      chk("first tick", 32'(c0 <= (1 << (s + cctb_pkg::PRESCALE_BASE)) + 2), 32'h1);
      chk("interval", c1, 32'(1 << (s + cctb_pkg::PRESCALE_BASE)));
    end
    v = 16'($urandom_range(16'hfff0));
    wr(tr(0), v);
    wr(tv(0), 16'hfffe);
    setctl(0, 8'h40);
    wait_irq(0, c0);
    setctl(0, 8'h00);
    rdchk("reload", tv(0), {16'h0, v});
    // both unit1 timers overflow together: b lags a by one clock
    for (t = 0; t < 2; t++) begin
      wr(tr(t), 16'hffff);
      wr(tv(t), 16'hffff);
    end
    wr(cctb_pkg::UNIT1_TIMER_CONTROL_OFS, 16'h4040);
    for (n = 0; n < 3; n++) begin
      wait_irq(0, c0);
      @(posedge clk);
      chk("b lag", t_irq[1], 32'h1);
    end
    wr(cctb_pkg::UNIT1_TIMER_CONTROL_OFS, 16'h0);
    // pin counting for each edge selection
    for (t = 0; t < 4; t += 2) begin
      for (s = 1; s < 4; s++) begin
        wr(tv(t), 16'h0);
        setctl(t, 8'h48 | 8'(s));
        e = 0;
        repeat (4) begin
          e += counts(s, ~cnt_pin[t / 2]);
          flip <= 2'(1 << (t / 2));
          @(posedge clk);
          flip <= 2'h0;
          repeat (8) @(posedge clk);
        end
        rdchk("pin count", tv(t), 32'(e));
        setctl(t, 8'h00);
      end
    end
    // neighbour overflow as count source; b stops on pin selections
    for (t = 0; t < 4; t++) begin
      wr(tv(t), 16'h0);
      setctl(t, 8'h48 | 8'(4 * $urandom_range(1)));
      n = $urandom_range(5, 1);
      repeat (n) pulse();
      rdchk("ovf count", tv(t), 32'(n));
      if (t[0]) begin
        setctl(t, 8'h48 | 8'($urandom_range(3, 1)));
        repeat (3) pulse();
        rdchk("b stopped", tv(t), 32'(n));
      end
      setctl(t, 8'h00);
    end
    // capture on a rising, falling or either pin edge, timer a or b of the unit
    for (n = 0; n < 4; n++) begin
      k = $urandom_range(31);
      s = $urandom_range(1);
      t = (k >= 16 ? 2 : 0) + s;
      v = 16'($urandom);
      wr(tv(t), v);
      e = (n == 0) ? 1 : $urandom_range(3, 1);
      wr(cctb_pkg::CC_MODE_BASE + 16'(4 * k), 16'(s * 8) | 16'(e));
      c0 = 0;
      // rise then fall, each given eight clocks to show its pulse
      for (c1 = 0; c1 < 16; c1++) begin
        if (c1 % 8 == 0) begin
          cc_in[k] <= ~cc_in[k];
        end
        @(posedge clk);
        c0 += int'(cc_irq[k] === 1'b1);
      end
      chk("cap irq", c0, 32'(counts(e, 1'b1) + counts(e, 1'b0)));
      rdchk("capture", cctb_pkg::CC_VALUE_BASE + 16'(4 * k), {16'h0, v});
      wr(cctb_pkg::CC_MODE_BASE + 16'(4 * k), 16'h0);
    end
    // compare on match in toggle, set or irq modes; capture-only channels never drive
    for (n = 0; n < 6; n++) begin
      k = (n < 2) ? 24 + 3 * n : $urandom_range(31);
      t = (k >= 16) ? 2 : 0;
      v = 16'($urandom_range(16'hff00));
      wr(tv(t), v);
      wr(cctb_pkg::CC_VALUE_BASE + 16'(4 * k), v + 16'h1);
      e = (n < 3) ? 5 : (n == 3 ? 7 : $urandom_range(7, 4));
      wr(cctb_pkg::CC_MODE_BASE + 16'(4 * k), 16'(e));
      lvl = cc_out[k];
      capc = (k < 24 || k > 27);
      setctl(t, 8'h40);
      c0 = 0;
      repeat (20) begin
        @(posedge clk);
        c0 += int'(cc_irq[k] === 1'b1);
      end
      setctl(t, 8'h00);
      chk("cmp oe", cc_oe[k], {31'h0, capc});
      chk("cmp pin", cc_out[k], {31'h0, capc ? (e == 7 || (lvl ^ (e == 5))) : lvl});
      if (capc) begin
        chk("cmp irq", c0, 32'h1);
      end
      wr(cctb_pkg::CC_MODE_BASE + 16'(4 * k), 16'h0);
    end
    results();
  end
endmodule // tb_top
